//--- rtl/tptc_timing_core.sv
/*
 * tptc_timing_core: three-phase pwm timing unit with its register file on an
 * Avalon-MM slave (one wait state per access), shared centre-aligned counter,
 * sync pulse generation, setting capture and half-period status.
 * assumes one clock at the instruction rate and a synchronous bus master.
 */
`default_nettype none
module tptc_timing_core (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [tptc_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [tptc_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [tptc_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    output logic [tptc_pkg::PHASES-1:0] phaseHighOutputN,
    output logic [tptc_pkg::PHASES-1:0] phaseLowOutputN,
    output logic periodSyncPulse,
    output logic syncInterrupt,
    output logic [tptc_pkg::SEG_W-1:0] outputSegmentControlActive,
    output logic [tptc_pkg::CNT_W-1:0] minimumPulsewidthActive
);

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: request seen, answered one edge later

    logic ackQ_q, ackQ_d;
    logic [tptc_pkg::DATA_W-1:0] readdata_q, readdata_d;
    logic request, commit;
    logic [tptc_pkg::DATA_W-1:0] byteMask;

    assign request = read | write;
    assign commit = write & ackQ_q;
    assign waitrequest = request & ~ackQ_q;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            byteMask[i*8 +: 8] = {8{byteenable[i]}};
        end
    end

    function automatic logic [tptc_pkg::DATA_W-1:0] merge(
        input logic [tptc_pkg::DATA_W-1:0] old,
        input logic [tptc_pkg::DATA_W-1:0] wd,
        input logic [tptc_pkg::DATA_W-1:0] mask
    );
        merge = (old & ~mask) | (wd & mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // software-visible settings (staging copies; the double-mode bit acts at once)

    tptc_pkg::tptc_settings_s stage_q, stage_d;
    logic doubleMode_q, doubleMode_d;
    logic [tptc_pkg::DATA_W-1:0] wide;

    always_comb begin
        stage_d = stage_q;
        doubleMode_d = doubleMode_q;
        wide = '0;
        if (commit) begin
            case (address)
                tptc_pkg::OFS_HALF_PERIOD: begin
                    wide = merge({16'h0000, stage_q.halfPeriod}, writedata, byteMask);
                    stage_d.halfPeriod = wide[tptc_pkg::CNT_W-1:0];
                end
                tptc_pkg::OFS_DEAD_TIME: begin
                    wide = merge({22'h00_0000, stage_q.deadTime}, writedata, byteMask);
                    stage_d.deadTime = wide[tptc_pkg::DT_W-1:0];
                end
                tptc_pkg::OFS_MIN_PULSE: begin
                    wide = merge({16'h0000, stage_q.minPulse}, writedata, byteMask);
                    stage_d.minPulse = wide[tptc_pkg::CNT_W-1:0];
                end
                tptc_pkg::OFS_SYNC_WIDTH: begin
                    wide = merge({24'h00_0000, stage_q.syncWidth}, writedata, byteMask);
                    stage_d.syncWidth = wide[tptc_pkg::SYNCW_W-1:0];
                end
                tptc_pkg::OFS_DUTY_A: begin
                    wide = merge({16'h0000, stage_q.duty[0]}, writedata, byteMask);
                    stage_d.duty[0] = wide[tptc_pkg::CNT_W-1:0];
                end
                tptc_pkg::OFS_DUTY_B: begin
                    wide = merge({16'h0000, stage_q.duty[1]}, writedata, byteMask);
                    stage_d.duty[1] = wide[tptc_pkg::CNT_W-1:0];
                end
                tptc_pkg::OFS_DUTY_C: begin
                    wide = merge({16'h0000, stage_q.duty[2]}, writedata, byteMask);
                    stage_d.duty[2] = wide[tptc_pkg::CNT_W-1:0];
                end
                tptc_pkg::OFS_SEGMENT: begin
                    wide = merge({23'h00_0000, stage_q.segment}, writedata, byteMask);
                    stage_d.segment = wide[tptc_pkg::SEG_W-1:0];
                end
                tptc_pkg::OFS_MODE_CTRL: begin
                    wide = merge({25'h000_0000, doubleMode_q, 6'h00}, writedata, byteMask);
                    doubleMode_d = wide[tptc_pkg::MODE_DOUBLE_BIT];
                end
                default: begin
                    wide = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage_q <= tptc_pkg::RST_SETTINGS;
            doubleMode_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            doubleMode_q <= doubleMode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared half-period counter, sync pulse and setting capture

    tptc_pkg::tptc_settings_s active_q, active_d;
    logic [tptc_pkg::CNT_W-1:0] count_q, count_d;
    logic secondHalf_q, secondHalf_d;
    logic start_q, start_d;
    logic sync_q, sync_d;
    logic [tptc_pkg::SYNCW_W-1:0] syncLeft_q, syncLeft_d;
    logic irq_q, irq_d;
    logic halfEnd, newHalf, newSync;

    always_comb begin
        // a zero half-period still advances one cycle per half
        halfEnd = start_q | ({1'b0, count_q} + 17'h0_0001 >= {1'b0, active_q.halfPeriod});
        newHalf = start_q ? 1'b0 : ~secondHalf_q;
        newSync = halfEnd & (~newHalf | doubleMode_q);

        count_d = count_q + 16'h0001;
        secondHalf_d = secondHalf_q;
        active_d = active_q;
        sync_d = sync_q;
        syncLeft_d = syncLeft_q;
        irq_d = 1'b0;
        start_d = 1'b0;

        if (halfEnd) begin
            count_d = '0;
            secondHalf_d = newHalf;
        end

        if (newSync) begin
            // staging register values take effect with the rising sync edge
            active_d = stage_q;
            sync_d = 1'b1;
            syncLeft_d = stage_q.syncWidth;
            irq_d = 1'b1;
        end else if (sync_q) begin
            if (syncLeft_q == '0) begin
                sync_d = 1'b0;
            end else begin
                syncLeft_d = syncLeft_q - 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            active_q <= tptc_pkg::RST_SETTINGS;
            count_q <= '0;
            secondHalf_q <= 1'b0;
            start_q <= 1'b1;
            sync_q <= 1'b0;
            syncLeft_q <= '0;
            irq_q <= 1'b0;
        end else begin
            active_q <= active_d;
            count_q <= count_d;
            secondHalf_q <= secondHalf_d;
            start_q <= start_d;
            sync_q <= sync_d;
            syncLeft_q <= syncLeft_d;
            irq_q <= irq_d;
        end
    end

    assign periodSyncPulse = sync_q;
    assign syncInterrupt = irq_q;
    assign outputSegmentControlActive = active_q.segment;
    assign minimumPulsewidthActive = active_q.minPulse;

    ////////////////////////////////////////////////////////////////////////
    // three pairs against the one counter

    for (genvar p = 0; p < tptc_pkg::PHASES; p++) begin : gPair
        tptc_phase_pair uPair (
            .clock(clock),
            .resetn(resetn),
            .count(count_q),
            .secondHalf(secondHalf_q),
            .halfPeriod(active_q.halfPeriod),
            .deadTime(active_q.deadTime),
            .duty(active_q.duty[p]),
            .highN(phaseHighOutputN[p]),
            .lowN(phaseLowOutputN[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: staging values read back, status shows the live half

    always_comb begin
        readdata_d = readdata_q;
        if (request & ~ackQ_q) begin
            case (address)
                tptc_pkg::OFS_HALF_PERIOD: readdata_d = {16'h0000, stage_q.halfPeriod};
                tptc_pkg::OFS_DEAD_TIME: readdata_d = {22'h00_0000, stage_q.deadTime};
                tptc_pkg::OFS_MIN_PULSE: readdata_d = {16'h0000, stage_q.minPulse};
                tptc_pkg::OFS_SYNC_WIDTH: readdata_d = {24'h00_0000, stage_q.syncWidth};
                tptc_pkg::OFS_DUTY_A: readdata_d = {16'h0000, stage_q.duty[0]};
                tptc_pkg::OFS_DUTY_B: readdata_d = {16'h0000, stage_q.duty[1]};
                tptc_pkg::OFS_DUTY_C: readdata_d = {16'h0000, stage_q.duty[2]};
                tptc_pkg::OFS_SEGMENT: readdata_d = {23'h00_0000, stage_q.segment};
                tptc_pkg::OFS_MODE_CTRL: readdata_d = {25'h000_0000, doubleMode_q, 6'h00};
                tptc_pkg::OFS_SYS_STATUS: readdata_d = {28'h000_0000, secondHalf_q, 3'h0};
                default: readdata_d = '0;
            endcase
        end
        ackQ_d = request & ~ackQ_q;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            readdata_q <= '0;
            ackQ_q <= 1'b0;
        end else begin
            readdata_q <= readdata_d;
            ackQ_q <= ackQ_d;
        end
    end

    assign readdata = readdata_q;

endmodule
`default_nettype wire

//--- rtl/tptc_pkg.sv
/*
 * tptc_pkg: register map, field positions, reset values and the settings
 * carrier shared by the three-phase pwm timing core and its phase pairs.
 * assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
 */
`default_nettype none
package tptc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int DT_W = 10;
    localparam int SYNCW_W = 8;
    localparam int SEG_W = 9;
    localparam int PHASES = 3;

    // byte offsets
    localparam logic [ADDR_W-1:0] OFS_HALF_PERIOD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DEAD_TIME = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MIN_PULSE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SYNC_WIDTH = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_DUTY_A = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DUTY_B = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_DUTY_C = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SEGMENT = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_SYS_STATUS = 8'h24;

    localparam int MODE_DOUBLE_BIT = 6;
    localparam int STAT_HALF_BIT = 3;

    localparam logic [CNT_W-1:0] RST_HALF_PERIOD = 16'h0000;
    localparam logic [DT_W-1:0] RST_DEAD_TIME = 10'h000;
    localparam logic [CNT_W-1:0] RST_MIN_PULSE = 16'h0000;
    localparam logic [SYNCW_W-1:0] RST_SYNC_WIDTH = 8'h27;
    localparam logic [CNT_W-1:0] RST_DUTY = 16'h0000;
    localparam logic [SEG_W-1:0] RST_SEGMENT = 9'h000;

    typedef struct packed {
        logic [CNT_W-1:0] halfPeriod;
        logic [DT_W-1:0] deadTime;
        logic [CNT_W-1:0] minPulse;
        logic [SYNCW_W-1:0] syncWidth;
        logic [PHASES-1:0][CNT_W-1:0] duty;
        logic [SEG_W-1:0] segment;
    } tptc_settings_s;

    localparam tptc_settings_s RST_SETTINGS = '{
        halfPeriod: RST_HALF_PERIOD,
        deadTime: RST_DEAD_TIME,
        minPulse: RST_MIN_PULSE,
        syncWidth: RST_SYNC_WIDTH,
        duty: {PHASES{RST_DUTY}},
        segment: RST_SEGMENT
    };

endpackage
`default_nettype wire

//--- rtl/tptc_phase_pair.sv
/*
 * tptc_phase_pair: one complementary, dead-time adjusted, active-low pair,
 * compared against the shared half-period counter.
 * assumes count runs 0..halfPeriod-1 in each half and settings are stable
 * between sync edges.
 */
`default_nettype none
module tptc_phase_pair (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [tptc_pkg::CNT_W-1:0] count,
    input wire logic secondHalf,
    input wire logic [tptc_pkg::CNT_W-1:0] halfPeriod,
    input wire logic [tptc_pkg::DT_W-1:0] deadTime,
    input wire logic [tptc_pkg::CNT_W-1:0] duty,
    output logic highN,
    output logic lowN
);

    logic highN_q, highN_d;
    logic lowN_q, lowN_d;
    logic signed [17:0] c, tm, d, dt;
    logic highOn, lowOn;

    ////////////////////////////////////////////////////////////////////////
    // widened signed copies so duty-deadtime can go negative safely
    always_comb begin
        c = signed'({2'b00, count});
        tm = signed'({2'b00, halfPeriod});
        d = signed'({2'b00, duty});
        dt = signed'({8'h00, deadTime});
        // on-time centred on the period midpoint
        if (!secondHalf) begin
            highOn = (c >= tm - d + dt);
            lowOn = (c < tm - d - dt);
        end else begin
            highOn = (c < d - dt);
            lowOn = (c >= d + dt);
        end
        // both edges moved by dt: gap between the two is 2*dt
        highN_d = ~highOn;
        lowN_d = ~lowOn;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            highN_q <= 1'b1;
            lowN_q <= 1'b1;
        end else begin
            highN_q <= highN_d;
            lowN_q <= lowN_d;
        end
    end

    assign highN = highN_q;
    assign lowN = lowN_q;

endmodule
`default_nettype wire

//--- test/tptc_sva.sv
/*
 * tptc_sva: port-level checker for the three-phase pwm timing core.
 * assumes it is bound to tptc_timing_core and sees only its ports.
 */
`default_nettype none
module tptc_sva (
    input wire logic clock,
    input wire logic resetn,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic [tptc_pkg::PHASES-1:0] phaseHighOutputN,
    input wire logic [tptc_pkg::PHASES-1:0] phaseLowOutputN,
    input wire logic periodSyncPulse,
    input wire logic syncInterrupt,
    input wire logic [tptc_pkg::SEG_W-1:0] outputSegmentControlActive,
    input wire logic [tptc_pkg::CNT_W-1:0] minimumPulsewidthActive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    a_irq_on_rise: assert property ($rose(periodSyncPulse) |-> syncInterrupt)
        else $error("sync rose without interrupt");
    a_irq_in_pulse: assert property (syncInterrupt |-> periodSyncPulse)
        else $error("interrupt outside sync pulse");
    a_pair_exclusive: assert property ((phaseHighOutputN | phaseLowOutputN) == '1)
        else $error("both switches of a pair on");
    a_seg_at_sync: assert property (!$stable(outputSegmentControlActive) |-> syncInterrupt)
        else $error("segment changed between sync edges");
    a_minpw_at_sync: assert property (!$stable(minimumPulsewidthActive) |-> syncInterrupt)
        else $error("min pulse changed between sync edges");
    // one wait state: first cycle stalls, second completes
    a_wait_first: assert property ($rose(read) || $rose(write) |-> waitrequest)
        else $error("request not stalled in first cycle");
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("more than one wait state");
    a_wait_idle: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest without request");
endmodule
`default_nettype wire

//--- test/tptc_gate_model.sv
/*
 * tptc_gate_model: gate driver stand-in that counts cycles where both
 * switches of any pair would conduct.
 * assumes the six active-low timing outputs feed it directly.
 */
`default_nettype none
module tptc_gate_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [tptc_pkg::PHASES-1:0] highN,
    input wire logic [tptc_pkg::PHASES-1:0] lowN,
    output logic [15:0] shootCount
);
    timeunit 1ns;
    timeprecision 1ps;
    // low level turns the switch on, so both low is a short across the link
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shootCount <= 16'h0000;
        end else if ((~highN & ~lowN) != 3'b000) begin
            shootCount <= shootCount + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- test/tptc_timing_core_tb_top.sv
/*
 * tptc_timing_core_tb_top: register and waveform tests of the timing core.
 * assumes one 25 MHz clock and the one-wait-state Avalon slave of the core.
 */
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end
module tptc_timing_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock;
    logic resetn;
    logic [tptc_pkg::ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [tptc_pkg::DATA_W-1:0] writedata;
    logic [tptc_pkg::DATA_W-1:0] readdata;
    logic waitrequest;
    logic [tptc_pkg::PHASES-1:0] highN;
    logic [tptc_pkg::PHASES-1:0] lowN;
    logic periodSyncPulse;
    logic syncInterrupt;
    logic [tptc_pkg::SEG_W-1:0] segActive;
    logic [tptc_pkg::CNT_W-1:0] minPwActive;
    logic [15:0] shootCount;
    logic [31:0] rd;
    int failures;
    int checked;
    int per;
    int syncW;
    int hiOn [3];
    int loOn [3];
    int duty [3];
    int i;
    ////////////////////////////////////////////////////////////////////////
    tptc_timing_core i_dut (.clock(clock), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest), .phaseHighOutputN(highN),
        .phaseLowOutputN(lowN), .periodSyncPulse(periodSyncPulse),
        .syncInterrupt(syncInterrupt), .outputSegmentControlActive(segActive),
        .minimumPulsewidthActive(minPwActive));
    tptc_gate_model i_gate (.clock(clock), .resetn(resetn), .highN(highN), .lowN(lowN),
        .shootCount(shootCount));
    ////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic isWr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !isWr;
        write <= isWr;
        // held until an edge sees waitrequest low; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wait_sync();
        do begin
            @(negedge clock);
        end while (syncInterrupt !== 1'b1);
    endtask
    // counts one sync-to-sync span; two syncs first so the outputs settle
    task automatic measure();
        int j;
        wait_sync();
        wait_sync();
        per = 0;
        syncW = 0;
        hiOn = '{0, 0, 0};
        loOn = '{0, 0, 0};
        do begin
            per++;
            syncW += (periodSyncPulse === 1'b1);
            @(negedge clock);
            // outputs lag the counter one cycle, so they are taken one cycle later
            for (j = 0; j < 3; j++) begin
                hiOn[j] += (highN[j] === 1'b0);
                loOn[j] += (lowN[j] === 1'b0);
            end
        end while (syncInterrupt !== 1'b1 && per < 4000);
    endtask
    task automatic stop_test();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        stop_test();
    end
    initial begin
        resetn = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        failures = 0;
        checked = 0;
        duty = '{12, 8, 15};
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        bus(1'b0, tptc_pkg::OFS_SYNC_WIDTH, 32'h0000_0000);
        `CHK(rd, 32'h0000_0027)
        bus(1'b0, tptc_pkg::OFS_MODE_CTRL, 32'h0000_0000);
        `CHK(rd[tptc_pkg::MODE_DOUBLE_BIT], 1'b0)
        bus(1'b1, 8'h40, 32'h1234_5678);
        bus(1'b0, 8'h40, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        bus(1'b1, tptc_pkg::OFS_HALF_PERIOD, 32'h0000_0014);
        bus(1'b1, tptc_pkg::OFS_DEAD_TIME, 32'h0000_0002);
        bus(1'b1, tptc_pkg::OFS_SYNC_WIDTH, 32'h0000_0003);
        for (i = 0; i < 3; i++) begin
            bus(1'b1, tptc_pkg::OFS_DUTY_A + 8'(4 * i), 32'(duty[i]));
        end
        // extremes only right after a sync so they are never captured
        wait_sync();
        bus(1'b1, tptc_pkg::OFS_HALF_PERIOD, 32'hFFFF_FFFF);
        bus(1'b0, tptc_pkg::OFS_HALF_PERIOD, 32'h0000_0000);
        `CHK(rd, 32'h0000_FFFF)
        bus(1'b1, tptc_pkg::OFS_HALF_PERIOD, 32'h0000_0014);
        bus(1'b1, tptc_pkg::OFS_DEAD_TIME, 32'hFFFF_FFFF);
        bus(1'b0, tptc_pkg::OFS_DEAD_TIME, 32'h0000_0000);
        `CHK(rd, 32'h0000_03FF)
        bus(1'b1, tptc_pkg::OFS_DEAD_TIME, 32'h0000_0002);
        measure();
        `CHK(per, 40)
        `CHK(syncW, 4)
        for (i = 0; i < 3; i++) begin
            `CHK(hiOn[i], 2 * (duty[i] - 2))
            `CHK(loOn[i], 2 * (20 - duty[i] - 2))
        end
        wait_sync();
        bus(1'b0, tptc_pkg::OFS_SYS_STATUS, 32'h0000_0000);
        `CHK(rd[tptc_pkg::STAT_HALF_BIT], 1'b0)
        repeat (20) @(posedge clock);
        bus(1'b0, tptc_pkg::OFS_SYS_STATUS, 32'h0000_0000);
        `CHK(rd[tptc_pkg::STAT_HALF_BIT], 1'b1)
        bus(1'b1, tptc_pkg::OFS_MODE_CTRL, 32'h0000_0040);
        bus(1'b0, tptc_pkg::OFS_MODE_CTRL, 32'h0000_0000);
        `CHK(rd[tptc_pkg::MODE_DOUBLE_BIT], 1'b1)
        bus(1'b1, tptc_pkg::OFS_DEAD_TIME, 32'h0000_0000);
        bus(1'b1, tptc_pkg::OFS_SEGMENT, 32'h0000_01AB);
        bus(1'b1, tptc_pkg::OFS_MIN_PULSE, 32'h0000_0005);
        measure();
        `CHK(per, 20)
        `CHK(hiOn[0], duty[0])
        `CHK(loOn[0], 20 - duty[0])
        `CHK(segActive, 9'h1AB)
        `CHK(minPwActive, 16'h0005)
        `CHK(shootCount, 16'h0000)
        stop_test();
    end
endmodule
bind tptc_timing_core tptc_sva i_sva (.clock(clock), .resetn(resetn), .read(read),
    .write(write), .waitrequest(waitrequest), .phaseHighOutputN(phaseHighOutputN),
    .phaseLowOutputN(phaseLowOutputN), .periodSyncPulse(periodSyncPulse),
    .syncInterrupt(syncInterrupt), .outputSegmentControlActive(outputSegmentControlActive),
    .minimumPulsewidthActive(minimumPulsewidthActive));
`default_nettype wire
